// [rtl/idle_powerdown_control.v]
// idle and power-down controller with apb register access
`timescale 1ns/1ps
`include "pwr_ctl_defs.vh"

module idle_powerdown_control
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // wake sources
    input  wire        irq_pending,
    input  wire        ext_irq_pin_0,
    input  wire        ext_irq_pin_1,
    input  wire [3:0]  key_wake_inputs,
    // clock controls, resume and ram lock
    output reg         cpu_clk_en_q,
    output reg         osc_en_q,
    output reg         resume_q,
    output reg         ram_block_q
);
    // registers
    reg  [3:0]  power_control_q;
    reg  [7:0]  wake_config_q;
    reg         pin_wake_q;
    reg         pd_wait_pin_q;
    reg         ram_first_q;
    reg  [4:0]  ram_cnt_q;
    reg  [2:0]  mode_q;
    reg  [2:0]  mode_d;
    reg  [31:0] rdata_d;
    wire        key_wake;
    wire        key_busy;
    wire        pin_level;
    wire        wr;
    wire        rd;
    wire        idle_mode;
    wire        pd_mode;
    wire        pd_wake;
    wire        key_load;

    // wake state, reported in status bits [8:6]
    localparam [2:0] ST_RUN  = 3'h0;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_PD   = 3'h2;
    localparam [2:0] ST_PIN  = 3'h3;
    localparam [2:0] ST_KEY  = 3'h4;

    function addr_hit;
        input [11:0] a;
        input [11:0] ref_addr;
        begin
            addr_hit = (a[11:2] == ref_addr[11:2]);
        end
    endfunction

    function mapped_addr;
        input [11:0] a;
        begin
            mapped_addr = addr_hit(a, `PC_ADDR_POWER_CONTROL) |
                          addr_hit(a, `PC_ADDR_WAKE_CONFIG) |
                          addr_hit(a, `PC_ADDR_STATUS);
        end
    endfunction

    assign wr = psel & penable & pwrite;
    assign rd = psel & ~penable & ~pwrite;
    // wake_config: [3:0] key enables, [7:4] key active-high per input
    level_sync_hold u_keys
    (
        .pclk        (pclk),
        .presetn     (presetn),
        .level_in    (key_wake_inputs),
        .active_high (wake_config_q[7:4]),
        .enable      (wake_config_q[3:0]),
        .wake_q      (key_wake)
    );

    assign pd_mode   = power_control_q[`PC_BIT_POWERDOWN];
    // power-down wins over idle
    assign idle_mode = power_control_q[`PC_BIT_IDLE] & ~pd_mode;
    assign pin_level = ext_irq_pin_0 | ext_irq_pin_1;
    // only pins and keys end power-down
    assign pd_wake   = pd_mode & (pin_level | key_wake);
    assign key_load  = pd_mode & key_wake & ~pin_level;

    // fixed hold after a key wake so the key is still down when
    // software scans it; the count does not track the real oscillator
    cycle_counter u_keywait
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (key_load),
        .load_value (`PC_KEY_WAKE_CYCLES),
        .busy_q     (key_busy)
    );

    // presetn is the reset pin: clears both bits asynchronously
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_control_q <= `PC_POWER_CONTROL_RESET;
            pin_wake_q      <= 1'b0;
        end
        else
        begin
            pin_wake_q <= pin_level;
            // a write wins over a same-cycle hardware clear: the write
            // stands for the later instruction
            if (wr && addr_hit(paddr, `PC_ADDR_POWER_CONTROL))
                power_control_q <= pwdata[3:0];
            else if (pd_wake)
            begin
                // idle also dropped so no fall into idle afterwards
                power_control_q[`PC_BIT_POWERDOWN] <= 1'b0;
                power_control_q[`PC_BIT_IDLE]      <= 1'b0;
            end
            else if (idle_mode && irq_pending)
                power_control_q[`PC_BIT_IDLE] <= 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_config_q <= `PC_WAKE_CONFIG_RESET;
        else if (wr && addr_hit(paddr, `PC_ADDR_WAKE_CONFIG))
            wake_config_q <= pwdata[7:0];
    end

    // clock enables follow the mode bits the edge after the write
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_clk_en_q <= 1'b1;
            osc_en_q     <= 1'b1;
        end
        else
        begin
            osc_en_q     <= ~pd_mode | pd_wake;
            cpu_clk_en_q <= ~(pd_mode | idle_mode) | pd_wake |
                            (idle_mode & irq_pending);
        end
    end

    // resume held off until pin released or key count ends
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pd_wait_pin_q <= 1'b0;
            resume_q      <= 1'b1;
        end
        else
        begin
            if (pd_wake && pin_level)
                pd_wait_pin_q <= 1'b1;
            else if (!pin_wake_q)
                pd_wait_pin_q <= 1'b0;
            resume_q <= ~(pd_mode | idle_mode | key_load | key_busy |
                          (pd_wake & pin_level) |
                          (pd_wait_pin_q & pin_wake_q));
        end
    end

    // ram locked for a short window after reset release; registers
    // themselves stay intact on interrupt wake, none touched here
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ram_first_q <= 1'b1;
            ram_cnt_q   <= 5'h00;
            ram_block_q <= 1'b1;
        end
        else
        begin
            ram_first_q <= 1'b0;
            if (ram_first_q)
                ram_cnt_q <= `PC_RAM_BLOCK_CYCLES;
            else if (ram_cnt_q != 5'h00)
                ram_cnt_q <= ram_cnt_q - 5'h01;
            ram_block_q <= ram_first_q | (ram_cnt_q > 5'h01);
        end
    end

    // apb answer, zero wait states
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped_addr(paddr);
            if (rd)
                prdata <= rdata_d;
        end
    end

    // wake state mirrors the resume hold so software can see why the
    // cpu is held; it gates nothing itself
    always @*
    begin
        mode_d = mode_q;
        case (mode_q)
            ST_RUN:
            begin
                if (pd_mode)
                    mode_d = ST_PD;
                else if (idle_mode)
                    mode_d = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (pd_mode)
                    mode_d = ST_PD;
                else if (!idle_mode)
                    mode_d = ST_RUN;
            end
            ST_PD:
            begin
                if (pd_wake && pin_level)
                    mode_d = ST_PIN;
                else if (pd_wake)
                    mode_d = ST_KEY;
                else if (!pd_mode)
                    mode_d = ST_RUN;
            end
            ST_PIN:
            begin
                if (pd_mode)
                    mode_d = ST_PD;
                else if (!(pd_wait_pin_q && pin_wake_q))
                    mode_d = ST_RUN;
            end
            ST_KEY:
            begin
                if (pd_mode)
                    mode_d = ST_PD;
                else if (!key_busy)
                    mode_d = ST_RUN;
            end
            default:
                mode_d = ST_RUN;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_q <= ST_RUN;
        else
            mode_q <= mode_d;
    end

    // read mux; unmapped addresses and reserved bits read zero
    // status: [5:0] clock and wait flags, [8:6] wake state
    always @*
    begin
        rdata_d = 32'h0000_0000;
        if (addr_hit(paddr, `PC_ADDR_POWER_CONTROL))
            rdata_d = {28'h0000000, power_control_q};
        else if (addr_hit(paddr, `PC_ADDR_WAKE_CONFIG))
            rdata_d = {24'h000000, wake_config_q};
        else if (addr_hit(paddr, `PC_ADDR_STATUS))
            rdata_d = {23'h0, mode_q, key_busy, pd_wait_pin_q,
                       resume_q, ram_block_q, osc_en_q,
                       cpu_clk_en_q};
    end
endmodule

// [inc/pwr_ctl_defs.vh]
// constants for the idle / power-down controller
`ifndef PWR_CTL_DEFS_VH
`define PWR_CTL_DEFS_VH
`define PC_ADDR_POWER_CONTROL   12'h21C
`define PC_ADDR_WAKE_CONFIG     12'h220
`define PC_ADDR_STATUS          12'h224
`define PC_POWER_CONTROL_INDEX  8'h87
`define PC_BIT_IDLE             0
`define PC_BIT_POWERDOWN        1
`define PC_BIT_USER_FLAG_0      2
`define PC_BIT_USER_FLAG_1      3
`define PC_POWER_CONTROL_RESET  4'h0
`define PC_WAKE_CONFIG_RESET    8'h00
`define PC_KEY_WAKE_CYCLES      11'd1024
`define PC_RAM_BLOCK_CYCLES     5'd24
`endif

// [rtl/level_sync_hold.v]
// per-bit wake input qualifier: polarity and enable
`timescale 1ns/1ps
module level_sync_hold
(
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // wake level in, config
    input  wire [3:0] level_in,
    input  wire [3:0] active_high,
    input  wire [3:0] enable,
    // qualified wake
    output reg        wake_q
);
    wire [3:0] hit;
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_bit
            assign hit[i] = enable[i] &
                            ~(level_in[i] ^ active_high[i]);
        end
    endgenerate

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_q <= 1'b0;
        else
            wake_q <= |hit;
    end
endmodule

// [rtl/cycle_counter.v]
// down counter that flags done when it reaches zero
`timescale 1ns/1ps
module cycle_counter
(
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // load and count
    input  wire        load,
    input  wire [10:0] load_value,
    // status
    output reg         busy_q
);
    reg [10:0] count_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= 11'h000;
            busy_q  <= 1'b0;
        end
        else if (load)
        begin
            count_q <= load_value;
            busy_q  <= 1'b1;
        end
        else if (count_q != 11'h000)
        begin
            count_q <= count_q - 11'h001;
            busy_q  <= (count_q != 11'h001);
        end
        else
            busy_q <= 1'b0;
    end
endmodule

// [bench/wake_model.sv]
// interrupt logic and wake lines facing the controller
`timescale 1ns/1ps
module wake_model
(
    // clock
    input wire       pclk,
    // wake lines
    output reg       irq_pending,
    output reg       ext_irq_pin_0,
    output reg       ext_irq_pin_1,
    output reg [3:0] key_wake_inputs
);
    initial
    begin
        {ext_irq_pin_1, ext_irq_pin_0, irq_pending} = 3'h0;
        key_wake_inputs = 4'h0;
    end
    // levels hold until the bench moves them, never pulsed
    task drive(input [2:0] v);
        @(posedge pclk);
        {ext_irq_pin_1, ext_irq_pin_0, irq_pending} <= v;
    endtask
    task key(input [3:0] v);
        @(posedge pclk);
        key_wake_inputs <= v;
    endtask
endmodule

// [bench/pwr_sva.sv]
// assertions on the idle / power-down controller ports
`timescale 1ns/1ps
`include "pwr_ctl_defs.vh"
module pwr_sva
(
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    // wake and clock controls
    input wire        irq_pending,
    input wire        ext_irq_pin_0,
    input wire        ext_irq_pin_1,
    input wire        cpu_clk_en_q,
    input wire        osc_en_q,
    input wire        resume_q,
    input wire        ram_block_q
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire       pin = ext_irq_pin_0 | ext_irq_pin_1;
    wire       wr = psel & penable & pwrite;
    wire       pc = paddr == `PC_ADDR_POWER_CONTROL;
    reg [10:0] wait_q;
    reg [5:0]  up_q;
    reg        key_q;
    // key_q tells a key wake from a pin wake
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= 11'h000;
            up_q <= 6'h00;
            key_q <= 1'b0;
        end
        else
        begin
            wait_q <= (osc_en_q & ~resume_q) ? wait_q + 11'h001 : 11'h000;
            up_q <= (up_q == 6'h3F) ? up_q : up_q + 6'h01;
            if (!osc_en_q)
                key_q <= ~pin;
        end
    end
    sequence pd_wr; wr && pc && pwdata[1]; endsequence
    sequence all_off; !osc_en_q && !cpu_clk_en_q && !resume_q; endsequence
    pd_entry_a: assert property (pd_wr |-> ##2 all_off)
        else $error("no power-down");
    idle_entry_a: assert property (wr && pc && pwdata[1:0] == 2'h1
        |-> ##2 !cpu_clk_en_q && osc_en_q) else $error("no idle");
    idle_wake_a: assert property (!cpu_clk_en_q && osc_en_q
        && irq_pending && !wr |-> ##[1:2] cpu_clk_en_q)
        else $error("idle kept");
    pin_wake_a: assert property (!osc_en_q && pin |-> ##[1:2]
        osc_en_q && cpu_clk_en_q) else $error("pin wake missed");
    pin_hold_a: assert property (!resume_q && pin |=> !resume_q)
        else $error("resumed early");
    pin_go_a: assert property (osc_en_q && cpu_clk_en_q && !resume_q
        && !pin && !key_q |-> ##[0:3] resume_q) else $error("no resume");
    key_wait_a: assert property ($rose(resume_q) && key_q |->
        wait_q > 11'd1015 && wait_q < 11'd1035) else $error("key wait");
    ram_hold_a: assert property (up_q == 6'd12 |-> ram_block_q)
        else $error("ram open");
    reserved_a: assert property (pready && pc && !pwrite |->
        prdata[31:4] == 28'h0000000) else $error("reserved set");
endmodule
bind idle_powerdown_control pwr_sva u_sva
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .irq_pending(irq_pending),
    .ext_irq_pin_0(ext_irq_pin_0), .ext_irq_pin_1(ext_irq_pin_1),
    .cpu_clk_en_q(cpu_clk_en_q), .osc_en_q(osc_en_q),
    .resume_q(resume_q), .ram_block_q(ram_block_q)
);

// [bench/tb.sv]
// self-checking bench for the idle / power-down controller
`timescale 1ns/1ps
`include "pwr_ctl_defs.vh"
module tb;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000;
    reg  [31:0] rd;
    reg         err;
    wire [31:0] prdata;
    wire        pready, pslverr, irq, pin0, pin1, cpu, osc, res, rb;
    wire [3:0]  keys;
    wire [3:0]  st = {rb, res, osc, cpu};
    wire [11:0] pc = `PC_ADDR_POWER_CONTROL;
    int         n_mismatch = 0;
    int         n_checks = 0;
    int         i;
    always #12.5 pclk = ~pclk;
    idle_powerdown_control dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_pending(irq),
        .ext_irq_pin_0(pin0), .ext_irq_pin_1(pin1), .key_wake_inputs(keys),
        .cpu_clk_en_q(cpu), .osc_en_q(osc), .resume_q(res), .ram_block_q(rb)
    );
    wake_model wm
    (
        .pclk(pclk), .irq_pending(irq), .ext_irq_pin_0(pin0),
        .ext_irq_pin_1(pin1), .key_wake_inputs(keys)
    );
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input bit w, input [11:0] a, input [31:0] d);
        bit got;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        got = 1'b0;
        // answer read while settled, as the next rising edge samples it
        while (!got)
        begin
            @(negedge pclk);
            got = (pready === 1'b1);
            rd = prdata;
            err = pslverr;
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        wt(6);
        presetn <= 1'b1;
        chk(st, 4'hF);
        wt(40);
        chk(st, 4'h7);
        apb(0, pc, 0);
        chk(rd, 0);
        apb(0, 12'h300, 0);
        chk(rd, 0);
        chk(err, 1);
        apb(1, pc, 32'h0000000D);
        wt(3);
        chk(st, 4'h2);
        apb(0, pc, 0);
        chk(rd, 32'h0000000D);
        apb(0, `PC_ADDR_STATUS, 0);
        chk(rd, 32'h00000042);
        wm.drive(3'h1);
        wt(3);
        wm.drive(3'h0);
        chk(st, 4'h7);
        apb(0, pc, 0);
        chk(rd, 32'h0000000C);
        for (i = 1; i < 3; i++)
        begin
            apb(1, pc, 32'h0000000F);
            wt(3);
            chk(st, 4'h0);
            wm.drive(3'h1 << i);
            wt(20);
            chk(st, 4'h3);
            apb(0, `PC_ADDR_STATUS, 0);
            chk(rd, 32'h000000D3);
            wm.drive(3'h0);
            wt(6);
            chk(st, 4'h7);
            apb(0, pc, 0);
            chk(rd, 32'h0000000C);
        end
        // second pass wakes on a low level
        for (i = 0; i < 2; i++)
        begin
            apb(1, `PC_ADDR_WAKE_CONFIG, i ? 32'h02 : 32'h11);
            apb(0, `PC_ADDR_WAKE_CONFIG, 0);
            chk(rd, i ? 32'h02 : 32'h11);
            wm.key(i ? 4'hF : 4'h0);
            apb(1, pc, 32'h00000002);
            wm.drive(3'h1);
            wt(5);
            wm.drive(3'h0);
            chk(st, 4'h0);
            wm.key(i ? 4'hD : 4'h1);
            wt(1000);
            chk(st, 4'h3);
            apb(0, `PC_ADDR_STATUS, 0);
            chk(rd, 32'h00000123);
            wt(40);
            chk(st, 4'h7);
        end
        for (i = 1; i < 3; i++)
        begin
            apb(1, pc, i);
            wt(3);
            presetn <= 1'b0;
            #1;
            chk(st, 4'hF);
            wt(24);
            presetn <= 1'b1;
            apb(0, pc, 0);
            chk(rd, 0);
        end
        print_verdict;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        print_verdict;
    end
endmodule
